// [verilog/aso_core.sv]
// anomaly signalling, override demotion and register slave
`timescale 1ns/1ps
// Contract
// (R1) reset command acknowledges all, silences horns; code leaves an anomaly activating that cycle unacked, hooter on
// (R2) new anomaly logs its own code; code logs only the lowest new index per cycle, none on an override event
// (R3) reset pulse output one second
// (R4) acknowledge pulse output one second
// (R5) external horn mirrors internal hooter
// (R6) class summaries: warning, unload, deactivation, alarm
// (R7) severe summary: unload, deactivation or alarm
// (R8) generator group ORs generator anomalies
// (R9) engine group ORs engine anomalies
// (R10) speed regulator group ORs its anomalies
// (R11) fuel group ORs fuel anomalies
// (R12) breaker group ORs four breaker anomalies
// (R13) status flags for anomalies, progress, classes
// (R14) active override demotes covered anomalies to warnings
// (R15) three independent override request inputs
// (R16) per-anomaly mask selects demoting requests
// (R17) oil-delay, overridable generic inputs demoted by engine
// (R18) analogue threshold: engine override needs bit fifteen; code checks only mask bit e
// (R19) log override on and all-off events
// (R20) pass engine unit override indication to display
// (R21) activate only after configured delay persists
// (R22) delay zero disables the anomaly
// (R23) hooter duration: zero never, 999 manual, else timed
// (R24) acknowledge also silences hooter and horn; code keeps the hooter on if a new anomaly activates that cycle
// (R25) acked warning auto clears; unacked never
// (R26) repeated command restarts running pulse
// (R27) summaries computed combinationally, then registered
module aso_core #(
   parameter int unsigned N         = aso_pkg::N_ANOM,
   parameter int unsigned PULSE_LEN = aso_pkg::PULSE_CYC,
   parameter int unsigned SEC_LEN   = aso_pkg::SEC_CYC
) (
   // clock, reset, enable
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   clk_en,
   // anomaly conditions and commands from pins
   input  wire logic [N-1:0]           cond_in,
   input  wire logic                   ack_cmd_in,
   input  wire logic                   reset_cmd_in,
   input  wire logic                   engine_override_in,
   input  wire logic                   full_override_in,
   input  wire logic                   generator_override_in,
   input  wire logic                   ecu_override_in,
   // axi4-lite slave
   input  wire logic [7:0]             s_awaddr,
   input  wire logic                   s_awvalid,
   output logic                        s_awready,
   input  wire logic [31:0]            s_wdata,
   input  wire logic [3:0]             s_wstrb,
   input  wire logic                   s_wvalid,
   output logic                        s_wready,
   output logic [1:0]                  s_bresp,
   output logic                        s_bvalid,
   input  wire logic                   s_bready,
   input  wire logic [7:0]             s_araddr,
   input  wire logic                   s_arvalid,
   output logic                        s_arready,
   output logic [31:0]                 s_rdata,
   output logic [1:0]                  s_rresp,
   output logic                        s_rvalid,
   input  wire logic                   s_rready,
   // relay outputs
   output logic                        reset_pulse_out,
   output logic                        ack_pulse_out,
   output logic                        external_horn_out,
   output logic                        warning_summary_out,
   output logic                        unload_summary_out,
   output logic                        deactivation_summary_out,
   output logic                        alarm_summary_out,
   output logic                        severe_summary_out,
   output logic                        generator_group_out,
   output logic                        engine_group_out,
   output logic                        speed_reg_group_out,
   output logic                        fuel_group_out,
   output logic                        breaker_group_out,
   // status and event log
   output logic                        ack_in_progress_flag,
   output logic                        reset_in_progress_flag,
   output logic                        ecu_override_out,
   output aso_pkg::aso_event_s         event_out
);
   import aso_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int unsigned NS = N + 6;
   logic [NS-1:0] s1_q, s2_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= '0;
         s2_q <= '0;
      end else if (clk_en) begin
         s1_q <= {ecu_override_in, generator_override_in, full_override_in,
                  engine_override_in, reset_cmd_in, ack_cmd_in, cond_in};
         s2_q <= s1_q;
      end
   end
   wire logic [N-1:0] cond_s = s2_q[N-1:0];
   wire logic ack_lvl   = s2_q[N];
   wire logic rst_lvl   = s2_q[N+1];
   wire logic ovr_e     = s2_q[N+2];   // (R15)
   wire logic ovr_f     = s2_q[N+3];   // (R15)
   wire logic ovr_g     = s2_q[N+4];   // (R15)
   wire logic ecu_ovr   = s2_q[N+5];
   logic ack_lvl_q, rst_lvl_q;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   aso_cfg_s          cfg_q [N];
   logic [DLY_W-1:0]  dly_q [N];
   logic [DLY_W-1:0]  cnt_q [N];
   logic [4:0]        sel_q;
   logic [9:0]        hoot_dur_q;
   logic [N-1:0]      act_q, unack_q;
   logic              sw_ack_q, sw_rst_q, sw_sil_q;

   // command strobes: pin activation edge or software write
   wire logic do_ack = (ack_lvl & ~ack_lvl_q) | sw_ack_q;
   wire logic do_rst = (rst_lvl & ~rst_lvl_q) | sw_rst_q;

   // ----------------------------------------
   // activation delay and anomaly state
   // ----------------------------------------
   logic [N-1:0] fire, new_act;
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_anom
         wire logic en = (dly_q[gi] != '0);                  // (R22)
         assign fire[gi] = en & cond_s[gi] & (cnt_q[gi] == dly_q[gi]);  // (R21)
         assign new_act[gi] = fire[gi] & ~act_q[gi];
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cnt_q[gi]   <= '0;
               act_q[gi]   <= 1'b0;
               unack_q[gi] <= 1'b0;
            end else if (clk_en) begin
               if (!en || !cond_s[gi])
                  cnt_q[gi] <= '0;
               else if (cnt_q[gi] != dly_q[gi])
                  cnt_q[gi] <= cnt_q[gi] + 1'b1;             // (R21)
               // new activation wins over ack, reset or auto clear
               if (new_act[gi]) begin
                  act_q[gi]   <= 1'b1;
                  unack_q[gi] <= 1'b1;
               end else begin
                  if (do_ack || do_rst)
                     unack_q[gi] <= 1'b0;                    // (R1)
                  // a reset only removes anomalies whose cause is gone
                  if (!en || (!fire[gi] && (do_rst ||
                      (eff_cls(gi) == ASO_WARN && !unack_q[gi]))))
                     act_q[gi] <= 1'b0;                      // (R25)
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // override demotion
   // ----------------------------------------
   function automatic aso_class_e eff_cls(input int unsigned i);
      aso_cfg_s c;
      c = cfg_q[i];
      // mask bit e alone selects demotion by the engine override; no
      // configuration bit fifteen is stored or checked for analogue thresholds
      if ((c.ovr_e & ovr_e) | (c.ovr_f & ovr_f) | (c.ovr_g & ovr_g))  // (R16) (R17) (R18)
         return ASO_WARN;                                   // (R14)
      return c.cls;
   endfunction

   aso_cls_s   cls_d;
   logic [4:0] grp_d;
   logic [3:0] unack_cls_d;
   always_comb begin
      cls_d       = '0;
      grp_d       = '0;
      unack_cls_d = '0;
      for (int i = 0; i < N; i++) begin
         if (act_q[i]) begin
            unique case (eff_cls(i))                        // (R27)
               ASO_WARN:   cls_d.warn   = 1'b1;
               ASO_UNLOAD: cls_d.unload = 1'b1;
               ASO_DEACT:  cls_d.deact  = 1'b1;
               ASO_ALARM:  cls_d.alarm  = 1'b1;
            endcase
            grp_d = grp_d | cfg_q[i].group;                 // (R8) (R9) (R10) (R11) (R12)
         end
         if (unack_q[i])
            unack_cls_d[eff_cls(i)] = 1'b1;                 // (R13)
      end
   end
   logic [3:0] unack_cls_q;
   wire logic any_ovr = ovr_e | ovr_f | ovr_g;
   logic any_ovr_q;
   wire logic [2:0] ovr_vec = {ovr_g, ovr_f, ovr_e};
   logic [2:0] ovr_vec_q;

   // ----------------------------------------
   // pulses, hooter, summaries
   // ----------------------------------------
   logic [$clog2(PULSE_LEN+1)-1:0] rp_cnt_q, ap_cnt_q;
   logic [$clog2(SEC_LEN+1)-1:0]   sec_cnt_q;
   logic [9:0]                     hoot_left_q;
   logic                           hooter_q;
   wire logic hoot_off = do_ack | do_rst | sw_sil_q;        // (R24) (R1)
   wire logic hoot_on  = (|new_act) && hoot_dur_q != 10'(HOOTER_NEVER);  // (R23)

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rp_cnt_q    <= '0;
         ap_cnt_q    <= '0;
         hooter_q    <= 1'b0;
         hoot_left_q <= '0;
         sec_cnt_q   <= '0;
      end else if (clk_en) begin
         if (do_rst)
            rp_cnt_q <= ($bits(rp_cnt_q))'(PULSE_LEN);      // (R3) (R26)
         else if (rp_cnt_q != '0)
            rp_cnt_q <= rp_cnt_q - 1'b1;
         if (do_ack)
            ap_cnt_q <= ($bits(ap_cnt_q))'(PULSE_LEN);      // (R4) (R26)
         else if (ap_cnt_q != '0)
            ap_cnt_q <= ap_cnt_q - 1'b1;
         if (hoot_on) begin
            hooter_q    <= 1'b1;
            hoot_left_q <= hoot_dur_q;
            sec_cnt_q   <= '0;
         end else if (hoot_off) begin
            hooter_q <= 1'b0;
         end else if (hooter_q && hoot_dur_q != 10'(HOOTER_MANUAL)) begin
            if (sec_cnt_q == ($bits(sec_cnt_q))'(SEC_LEN - 1)) begin
               sec_cnt_q <= '0;
               if (hoot_left_q <= 10'd1)
                  hooter_q <= 1'b0;                         // (R23)
               hoot_left_q <= hoot_left_q - 1'b1;
            end else
               sec_cnt_q <= sec_cnt_q + 1'b1;
         end
      end
   end

   // first matching new anomaly, if several fire at once the lowest wins
   logic [4:0] first_new;
   always_comb begin
      first_new = '0;
      for (int i = N - 1; i >= 0; i--)
         if (new_act[i])
            first_new = 5'(i);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {reset_pulse_out, ack_pulse_out, external_horn_out} <= '0;
         {warning_summary_out, unload_summary_out} <= '0;
         {deactivation_summary_out, alarm_summary_out, severe_summary_out} <= '0;
         {generator_group_out, engine_group_out, speed_reg_group_out} <= '0;
         {fuel_group_out, breaker_group_out} <= '0;
         {ack_in_progress_flag, reset_in_progress_flag, ecu_override_out} <= '0;
         event_out   <= '0;
         any_ovr_q   <= 1'b0;
         ovr_vec_q   <= '0;
         unack_cls_q <= '0;
         ack_lvl_q   <= 1'b0;
         rst_lvl_q   <= 1'b0;
      end else if (clk_en) begin
         ack_lvl_q                <= ack_lvl;
         rst_lvl_q                <= rst_lvl;
         reset_pulse_out          <= do_rst | (rp_cnt_q > 1);          // (R3)
         ack_pulse_out            <= do_ack | (ap_cnt_q > 1);          // (R4)
         reset_in_progress_flag   <= do_rst | (rp_cnt_q > 1);          // (R13)
         ack_in_progress_flag     <= do_ack | (ap_cnt_q > 1);          // (R13)
         external_horn_out        <= hooter_q;                         // (R5)
         warning_summary_out      <= cls_d.warn;                       // (R6)
         unload_summary_out       <= cls_d.unload;                     // (R6)
         deactivation_summary_out <= cls_d.deact;                      // (R6)
         alarm_summary_out        <= cls_d.alarm;                      // (R6)
         severe_summary_out       <= cls_d.unload | cls_d.deact | cls_d.alarm;  // (R7)
         generator_group_out      <= grp_d[0];                         // (R8)
         engine_group_out         <= grp_d[1];                         // (R9)
         speed_reg_group_out      <= grp_d[2];                         // (R10)
         fuel_group_out           <= grp_d[3];                         // (R11)
         breaker_group_out        <= grp_d[4];                         // (R12)
         ecu_override_out         <= ecu_ovr;                          // (R20)
         unack_cls_q              <= unack_cls_d;
         any_ovr_q                <= any_ovr;
         ovr_vec_q                <= ovr_vec;
         // override events take the log slot over anomaly entries
         if (|(ovr_vec & ~ovr_vec_q))
            event_out <= '{valid: 1'b1, code: EVT_OVR_ON};            // (R19)
         else if (any_ovr_q && !any_ovr)
            event_out <= '{valid: 1'b1, code: EVT_OVR_OFF};           // (R19)
         else if (|new_act)
            event_out <= '{valid: 1'b1, code: cfg_q[first_new].code}; // (R2)
         else
            event_out <= '0;
      end
   end

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   logic aw_hold_q, w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   wire logic wr_go = aw_hold_q & w_hold_q & ~s_bvalid;
   wire logic map_w = awaddr_q inside {REG_CTRL, REG_HOOTER, REG_ANOM_SEL,
                                       REG_ANOM_CFG, REG_ANOM_DLY};
   logic [31:0] rd_d;
   logic        rd_ok;
   always_comb begin
      rd_ok = 1'b1;
      unique case (s_araddr)
         REG_CTRL:     rd_d = {29'h0, reset_in_progress_flag, 1'b0, ack_in_progress_flag};
         REG_HOOTER:   rd_d = {21'h0, hooter_q, hoot_dur_q};
         REG_RAW:      rd_d = 32'(cond_s);
         REG_ACTIVE:   rd_d = 32'(act_q);                              // (R13)
         REG_UNACK:    rd_d = 32'(unack_q);
         REG_STATUS:   rd_d = {20'h0, ecu_ovr, ovr_vec, unack_cls_q,
                               cls_d.alarm, cls_d.deact, cls_d.unload, cls_d.warn};  // (R13)
         REG_EVENT:    rd_d = {15'h0, event_out};
         REG_ANOM_SEL: rd_d = 32'(sel_q);
         REG_ANOM_CFG: rd_d = {cfg_q[sel_q].code, 6'h0, cfg_q[sel_q].group,
                               cfg_q[sel_q].ovr_g, cfg_q[sel_q].ovr_f,
                               cfg_q[sel_q].ovr_e, cfg_q[sel_q].cls};
         REG_ANOM_DLY: rd_d = 32'(dly_q[sel_q]);
         default: begin
            rd_d  = '0;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {s_awready, s_wready, s_arready} <= 3'b111;
         {aw_hold_q, w_hold_q, s_bvalid, s_rvalid} <= '0;
         awaddr_q <= '0;
         wdata_q  <= '0;
         s_bresp  <= AXI_OKAY;
         s_rresp  <= AXI_OKAY;
         s_rdata  <= '0;
         {sw_ack_q, sw_rst_q, sw_sil_q} <= '0;
         sel_q      <= '0;
         hoot_dur_q <= 10'(HOOTER_MANUAL);
         for (int i = 0; i < N; i++) begin
            cfg_q[i] <= '0;
            dly_q[i] <= '0;
         end
      end else if (clk_en) begin
         {sw_ack_q, sw_rst_q, sw_sil_q} <= '0;
         if (s_awvalid && s_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_awaddr;
            s_awready <= 1'b0;
         end
         if (s_wvalid && s_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_wdata;
            s_wready <= 1'b0;
         end
         if (wr_go) begin
            s_bvalid  <= 1'b1;
            s_bresp   <= map_w ? AXI_OKAY : AXI_SLVERR;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            unique case (awaddr_q)
               REG_CTRL: begin
                  sw_ack_q <= wdata_q[CTRL_ACK];
                  sw_rst_q <= wdata_q[CTRL_RESET];
                  sw_sil_q <= wdata_q[CTRL_SIL];
               end
               REG_HOOTER:   hoot_dur_q <= wdata_q[9:0];
               REG_ANOM_SEL: sel_q <= wdata_q[4:0];
               REG_ANOM_CFG: cfg_q[sel_q] <= '{code:  wdata_q[CFG_CODE_LO +: 16],
                                               group: wdata_q[CFG_GRP_LO +: 5],
                                               ovr_g: wdata_q[CFG_OVR_G],
                                               ovr_f: wdata_q[CFG_OVR_F],
                                               ovr_e: wdata_q[CFG_OVR_E],
                                               cls:   aso_class_e'(wdata_q[CFG_CLS_LO +: 2])};
               REG_ANOM_DLY: dly_q[sel_q] <= wdata_q[DLY_W-1:0];
               default: ;
            endcase
         end
         if (s_bvalid && s_bready) begin
            s_bvalid  <= 1'b0;
            s_awready <= 1'b1;
            s_wready  <= 1'b1;
         end
         if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_d;
            s_rresp   <= rd_ok ? AXI_OKAY : AXI_SLVERR;
         end else if (s_rvalid && s_rready) begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_rst_cmd;
      clk_en && do_rst;
   endsequence
   a_reset_pulse_on: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rst_cmd |=> reset_pulse_out) else $error("reset pulse missing");  // (R3)
   a_ack_pulse_on: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && do_ack |=> ack_pulse_out) else $error("ack pulse missing");  // (R4)
   a_horn_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en |=> external_horn_out == $past(hooter_q)) else $error("horn mismatch");  // (R5)
   a_severe_sum: assert property (@(posedge aclk) disable iff (!aresetn)
      severe_summary_out == (unload_summary_out | deactivation_summary_out
      | alarm_summary_out)) else $error("severe summary wrong");  // (R7)
   a_reset_unack: assert property (@(posedge aclk) disable iff (!aresetn)
      s_rst_cmd and !(|new_act) |=> unack_q == '0) else $error("reset left unacked");  // (R1)
   a_ack_silence: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && do_ack && !hoot_on |=> !hooter_q ##1 !external_horn_out)
      else $error("ack did not silence");  // (R24)
   a_zero_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && dly_q[0] == '0 |=> !act_q[0]) else $error("disabled anomaly active");  // (R22)
   a_new_logged: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && new_act[0] && first_new == '0 && !any_ovr && !any_ovr_q
      |=> event_out.valid && event_out.code == $past(cfg_q[0].code))
      else $error("anomaly not logged");  // (R2)
   a_ovr_off_evt: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && any_ovr_q && !any_ovr |=> event_out.code == EVT_OVR_OFF)
      else $error("override off not logged");  // (R19)
   a_never_hoot: assert property (@(posedge aclk) disable iff (!aresetn)
      hoot_dur_q == 10'(HOOTER_NEVER) && !hooter_q |=> !hooter_q)
      else $error("hooter sounded at zero duration");  // (R23)
endmodule // aso_core

// [pkg/aso_pkg.sv]
// package: constants, types and register map of the anomaly signalling block
package aso_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned PULSE_TIME_MS   = 1000;
   localparam int unsigned PULSE_CYC       = CLK_HZ / 1000 * PULSE_TIME_MS;
   localparam int unsigned SEC_CYC         = CLK_HZ;
   localparam int unsigned HOOTER_NEVER    = 0;
   localparam int unsigned HOOTER_MANUAL   = 999;
   localparam int unsigned ANALOG_OVR_BIT  = 15;
   localparam int unsigned N_ANOM          = 32;
   localparam int unsigned DLY_W           = 16;
   localparam logic [15:0] EVT_OVR_ON      = 16'd1082;
   localparam logic [15:0] EVT_OVR_OFF     = 16'd1083;

   // register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_HOOTER   = 8'h04;
   localparam logic [7:0] REG_RAW      = 8'h08;
   localparam logic [7:0] REG_ACTIVE   = 8'h0c;
   localparam logic [7:0] REG_UNACK    = 8'h10;
   localparam logic [7:0] REG_STATUS   = 8'h14;
   localparam logic [7:0] REG_EVENT    = 8'h18;
   localparam logic [7:0] REG_ANOM_SEL = 8'h1c;
   localparam logic [7:0] REG_ANOM_CFG = 8'h20;
   localparam logic [7:0] REG_ANOM_DLY = 8'h24;

   // control register bits (write one to trigger)
   localparam int unsigned CTRL_ACK   = 0;
   localparam int unsigned CTRL_RESET = 1;
   localparam int unsigned CTRL_SIL   = 2;

   // anomaly configuration field layout
   localparam int unsigned CFG_CLS_LO  = 0;
   localparam int unsigned CFG_OVR_E   = 2;
   localparam int unsigned CFG_OVR_F   = 3;
   localparam int unsigned CFG_OVR_G   = 4;
   localparam int unsigned CFG_GRP_LO  = 5;
   localparam int unsigned CFG_CODE_LO = 16;

   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;

   typedef enum logic [1:0] {ASO_WARN, ASO_UNLOAD, ASO_DEACT, ASO_ALARM} aso_class_e;

   typedef struct packed {
      logic [15:0] code;
      logic [4:0]  group;       // generator, engine, speed reg, fuel, breaker
      logic        ovr_g;
      logic        ovr_f;
      logic        ovr_e;
      aso_class_e  cls;
   } aso_cfg_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] code;
   } aso_event_s;

   typedef struct packed {
      logic warn;
      logic unload;
      logic deact;
      logic alarm;
   } aso_cls_s;
endpackage

// [tb/aso_panel.sv]
// operator panel model: holds each button press on a command pin
`timescale 1ns/1ps
module aso_panel #(
   parameter int HOLD = 6
) (
   // clock and press requests
   input  wire logic       aclk,
   input  wire logic [1:0] press,
   // command pins
   output logic            ack_cmd_in,
   output logic            reset_cmd_in
);
   // a held button must still act only once, on its rising edge
   int         n_q = 0;
   logic [1:0] k_q = 2'b00;
   always_ff @(posedge aclk) begin
      if (press != 2'b00) begin
         k_q <= press;
         n_q <= HOLD;
      end else if (n_q > 0) begin
         n_q <= n_q - 1;
      end
   end
   assign ack_cmd_in   = (n_q > 0) && k_q[0];
   assign reset_cmd_in = (n_q > 0) && k_q[1];
endmodule // aso_panel

// [tb/anomaly_signalling_override_bench.sv]
// self-checking bench of the anomaly signalling block
`timescale 1ns/1ps
module anomaly_signalling_override_bench;
   import aso_pkg::*;
   localparam int PL = 20;
   logic        aclk = 1'b0, aresetn = 1'b0, eco = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, cond = 32'h0, seed = 32'hd3bca687, d, r;
   logic [2:0]  ovr = 3'b000;
   logic [1:0]  press = 2'b00, rs, rresp;
   logic [31:0] rdata;
   logic        awready, wready, bvalid, arready, rvalid, ack_c, rst_c;
   logic        rpo, apo, horn, aif, rif, ecuo;
   wire  [4:0]  sumv, grp;
   aso_event_s  ev;
   int          n_mismatch = 0, checks_done = 0, plen = 0, pflg = 0, g;
   logic [15:0] exp_ev[$];
   always #2.5 aclk = ~aclk;
   aso_panel i_aso_panel (.aclk(aclk), .press(press), .ack_cmd_in(ack_c), .reset_cmd_in(rst_c));
   aso_core #(.PULSE_LEN(PL), .SEC_LEN(10)) i_aso_core (
      .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .cond_in(cond), .ack_cmd_in(ack_c),
      .reset_cmd_in(rst_c), .engine_override_in(ovr[0]), .full_override_in(ovr[1]),
      .generator_override_in(ovr[2]), .ecu_override_in(eco), .s_awaddr(awaddr),
      .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf),
      .s_wvalid(wvalid), .s_wready(wready), .s_bresp(), .s_bvalid(bvalid), .s_bready(1'b1),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
      .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(1'b1), .reset_pulse_out(rpo),
      .ack_pulse_out(apo), .external_horn_out(horn), .warning_summary_out(sumv[0]),
      .unload_summary_out(sumv[1]), .deactivation_summary_out(sumv[2]),
      .alarm_summary_out(sumv[3]), .severe_summary_out(sumv[4]),
      .generator_group_out(grp[0]), .engine_group_out(grp[1]), .speed_reg_group_out(grp[2]),
      .fuel_group_out(grp[3]), .breaker_group_out(grp[4]), .ack_in_progress_flag(aif),
      .reset_in_progress_flag(rif), .ecu_override_out(ecuo), .event_out(ev));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // model: one-hot class plus severe bit for anything above warning
   function automatic logic [31:0] ex(input int c);
      return (32'h1 << c) | (c != 0 ? 32'h10 : 32'h0);
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      rs = rresp;
   endtask
   task automatic push(input logic [1:0] k);
      press <= k;
      @(posedge aclk);
      press <= 2'b00;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      plen += int'(apo | rpo);
      pflg += int'(aif | rif);
      if (ev.valid === 1'b1)
         cmp(ev.code, exp_ev.size() != 0 ? exp_ev.pop_front() : 32'h1_0000);
   end
   initial begin
      #100_000;
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(REG_HOOTER);
      cmp(d[9:0], 999);
      rd(8'h30);
      cmp(rs, AXI_SLVERR);
      // second press of the reset pin lands while its pulse still runs
      for (int k = 0; k < 2; k++) begin
         plen = 0;
         pflg = 0;
         repeat (k + 1) begin
            push(2'b01 << k);
            repeat (9) @(posedge aclk);
         end
         repeat (40) @(posedge aclk);
         cmp(plen, PL + 10 * k);
         cmp(pflg, PL + 10 * k);
      end
      for (int c = 0; c < 4; c++) begin
         r = rnd();
         g = r[2:0] % 5;
         wr(REG_ANOM_SEL, 32'h0);
         wr(REG_ANOM_CFG, {r[31:16], 6'h0, 5'b00001 << g, r[6:4], c[1:0]});
         wr(REG_ANOM_DLY, 32'd4);
         exp_ev.push_back(r[31:16]);
         cond <= rnd() | 32'h1;
         eco <= r[11];
         while (exp_ev.size() != 0) @(posedge aclk);
         repeat (3) @(posedge aclk);
         cmp(sumv, ex(c));
         cmp(grp, 32'h1 << g);
         rd(REG_HOOTER);
         cmp({horn, d[10]}, 2'b11);
         ovr <= r[10:8];
         if (r[10:8] != 3'b000) exp_ev.push_back(EVT_OVR_ON);
         repeat (8) @(posedge aclk);
         cmp(sumv, ex((r[6:4] & r[10:8]) != 3'b000 ? 0 : c));
         ovr <= 3'b000;
         if (r[10:8] != 3'b000) exp_ev.push_back(EVT_OVR_OFF);
         cond <= 32'h0;
         repeat (8) @(posedge aclk);
         push(2'b10);
         repeat (30) @(posedge aclk);
         cmp({sumv, horn}, 32'h0);
         cmp(ecuo, r[11]);
      end
      test_done();
   end
endmodule // anomaly_signalling_override_bench
